// [core/rcac_core.sv]
// Command interpreter for readout, channel enable and offset opcodes.
// Assumes an APB master on pclk; event strobes come from pclk logic.
`include "rcac_defs.svh"
module rcac_core
  import rcac_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Settings to the chips
  output rcac_pkg::rcac_cfg_type cfg,
  output logic      [127:0]      chan_en,
  input  wire logic [6:0]        adj_sel,
  output logic      [7:0]        adj_val,
  // Event composition
  input  wire logic              ev_hit,
  input  wire logic              ev_end,
  output logic                   err_valid,
  output logic      [15:0]       err_word,
  output logic                   trl_go
);
  import rcac_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Operand words written after an opcode
  function automatic logic [3:0] wr_count(input logic [7:0] cmd, input logic nar);
    unique case (cmd)
      `RCAC_OP_HL_WR, `RCAC_OP_EM_WR, `RCAC_OP_BS_WR,
      `RCAC_OP_ADJ_WR: wr_count = 4'h1;
      `RCAC_OP_CP_WR, `RCAC_OP_GO_WR: wr_count = 4'h2;
      `RCAC_OP_PAT_WR: wr_count = nar ? `RCAC_PW_NARROW : `RCAC_PW_WIDE;
      default:         wr_count = 4'h0;
    endcase
  endfunction

  // Operand words read after an opcode
  function automatic logic [3:0] rd_count(input logic [7:0] cmd, input logic nar);
    unique case (cmd)
      `RCAC_OP_HT_RD, `RCAC_OP_HL_RD, `RCAC_OP_EM_RD, `RCAC_OP_BS_RD,
      `RCAC_OP_ADJ_RD: rd_count = 4'h1;
      `RCAC_OP_CP_RD, `RCAC_OP_GO_RD: rd_count = 4'h2;
      `RCAC_OP_PAT_RD: rd_count = nar ? `RCAC_PW_NARROW : `RCAC_PW_WIDE;
      default:         rd_count = 4'h0;
    endcase
  endfunction

  // Hit limit code to count; codes above eight mean unlimited
  function automatic logic [8:0] hl_value(input logic [3:0] code);
    hl_value = (code == 4'h0) ? 9'h000 : 9'(9'h001 << (code - 4'h1));
  endfunction

  // ----------------------------------------
  // Interpreter state
  // ----------------------------------------
  rcac_state_type st_q, st_d;
  logic [15:0]    op_q, op_d;
  logic [3:0]     left_q, left_d;
  logic [3:0]     idx_q, idx_d;
  logic           narrow_q, narrow_d;
  rcac_cfg_type   cfg_q, cfg_d;
  logic [127:0]   en_q, en_d;
  logic [7:0]     adj_q [128];
  logic [7:0]     adj_d [128];
  logic [7:0]     adj_val_q;

  logic           acc, wr_cmd, rd_cmd, mapped;
  logic [7:0]     hi_b, lo_b, new_hi, new_lo;
  logic           ch_ok, cp_ok, new_ch_ok;
  logic [6:0]     pat_base, cp_base;
  logic [15:0]    rd_word;

  // Access decode; access phase completes at once while enabled
  assign pready = ce;
  assign acc    = psel & penable & ce;
  assign wr_cmd = acc & pwrite & (paddr == `RCAC_ADDR_CMD);
  assign rd_cmd = acc & ~pwrite & (paddr == `RCAC_ADDR_CMD);
  assign mapped = (paddr == `RCAC_ADDR_CMD) | (paddr == `RCAC_ADDR_STAT)
                | (paddr == `RCAC_ADDR_CFG);

  // Command byte and index byte of pending and arriving opcodes
  assign hi_b      = op_q[15:8];
  assign lo_b      = op_q[7:0];
  assign new_hi    = pwdata[15:8];
  assign new_lo    = pwdata[7:0];
  assign ch_ok     = lo_b < (narrow_q ? `RCAC_NCH_NARROW : `RCAC_NCH_WIDE);
  assign new_ch_ok = new_lo < (narrow_q ? `RCAC_NCH_NARROW : `RCAC_NCH_WIDE);
  assign cp_ok     = lo_b < (narrow_q ? `RCAC_NCP_NARROW : `RCAC_NCP_WIDE);
  assign pat_base  = {idx_q[2:0], 4'h0};
  assign cp_base   = {lo_b[1:0], idx_q[0], 4'h0};

  // Word returned for the pending read opcode
  always_comb begin
    unique case (hi_b)
      `RCAC_OP_HT_RD:  rd_word = {15'h0000, cfg_q.hdr_trl_en};
      `RCAC_OP_HL_RD:  rd_word = {12'h000, cfg_q.hit_limit};
      `RCAC_OP_EM_RD:  rd_word = {5'h00, cfg_q.err_mask};
      `RCAC_OP_BS_RD:  rd_word = {13'h0000, cfg_q.buf_size};
      `RCAC_OP_PAT_RD: rd_word = en_q[pat_base +: 16];
      `RCAC_OP_CP_RD:  rd_word = cp_ok ? en_q[cp_base +: 16] : 16'h0000;
      `RCAC_OP_GO_RD:  rd_word = (idx_q == 4'h0) ? {5'h00, cfg_q.coarse_ofs}
                                                 : {11'h000, cfg_q.fine_ofs};
      `RCAC_OP_ADJ_RD: rd_word = {8'h00, adj_q[lo_b[6:0]]};
      default:         rd_word = 16'h0000;
    endcase
  end

  // Read data and error answer
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (psel && penable) begin
      if (!mapped) begin
        pslverr = 1'b1;
      end else if (paddr == `RCAC_ADDR_CMD) begin
        if (!pwrite) begin
          pslverr = (st_q != ST_RD);
          prdata  = (st_q == ST_RD) ? {16'h0000, rd_word} : 32'h0000_0000;
        end else begin
          pslverr = (st_q == ST_RD);
        end
      end else if (paddr == `RCAC_ADDR_STAT) begin
        prdata = {8'h00, op_q, left_q, 2'b00, st_q == ST_RD, st_q != ST_IDLE};
      end else begin
        prdata = {31'h0000_0000, narrow_q};
      end
    end
  end

  // Next state of the interpreter and its settings
  always_comb begin
    st_d     = st_q;
    op_d     = op_q;
    left_d   = left_q;
    idx_d    = idx_q;
    narrow_d = narrow_q;
    cfg_d    = cfg_q;
    en_d     = en_q;
    adj_d    = adj_q;
    if (acc && pwrite && paddr == `RCAC_ADDR_CFG && st_q == ST_IDLE) begin
      narrow_d = pwdata[0];
    end
    unique case (st_q)
      ST_IDLE: begin
        if (wr_cmd) begin
          op_d  = pwdata[15:0];
          idx_d = 4'h0;
          unique case (new_hi)
            `RCAC_OP_HT_ON:   cfg_d.hdr_trl_en  = 1'b1;
            `RCAC_OP_HT_OFF:  cfg_d.hdr_trl_en  = 1'b0;
            `RCAC_OP_MK_ON:   cfg_d.err_mark_en = 1'b1;
            `RCAC_OP_MK_OFF:  cfg_d.err_mark_en = 1'b0;
            `RCAC_OP_BY_ON:   cfg_d.bypass_en   = 1'b1;
            `RCAC_OP_BY_OFF:  cfg_d.bypass_en   = 1'b0;
            `RCAC_OP_CH_ON:   if (new_ch_ok) en_d[new_lo[6:0]] = 1'b1;
            `RCAC_OP_CH_OFF:  if (new_ch_ok) en_d[new_lo[6:0]] = 1'b0;
            `RCAC_OP_ALL_ON:  en_d = {128{1'b1}};
            `RCAC_OP_ALL_OFF: en_d = '0;
            default: ;
          endcase
          // Enter the operand phase the opcode asks for
          if (wr_count(new_hi, narrow_q) != 4'h0) begin
            st_d   = ST_WR;
            left_d = wr_count(new_hi, narrow_q);
          end else if (rd_count(new_hi, narrow_q) != 4'h0) begin
            st_d   = ST_RD;
            left_d = rd_count(new_hi, narrow_q);
          end
        end
      end
      ST_WR: begin
        if (wr_cmd) begin
          unique case (hi_b)
            `RCAC_OP_HL_WR:  cfg_d.hit_limit = pwdata[3:0];
            `RCAC_OP_EM_WR:  cfg_d.err_mask  = pwdata[10:0];
            `RCAC_OP_BS_WR:  cfg_d.buf_size  = pwdata[2:0];
            `RCAC_OP_PAT_WR: en_d[pat_base +: 16] = pwdata[15:0];
            `RCAC_OP_CP_WR:  if (cp_ok) en_d[cp_base +: 16] = pwdata[15:0];
            `RCAC_OP_GO_WR: begin
              if (idx_q == 4'h0) cfg_d.coarse_ofs = pwdata[10:0];
              else cfg_d.fine_ofs = pwdata[4:0];
            end
            `RCAC_OP_ADJ_WR: if (ch_ok) adj_d[lo_b[6:0]] = pwdata[7:0];
            default: ;
          endcase
          idx_d  = idx_q + 4'h1;
          left_d = left_q - 4'h1;
          if (left_q == 4'h1) st_d = ST_IDLE;
        end
      end
      ST_RD: begin
        if (rd_cmd) begin
          idx_d  = idx_q + 4'h1;
          left_d = left_q - 4'h1;
          if (left_q == 4'h1) st_d = ST_IDLE;
        end
      end
    endcase
  end

  // Interpreter registers; settings apply at once, also mid-run, except narrow mode, which is taken only while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= ST_IDLE;
      op_q     <= 16'h0000;
      left_q   <= 4'h0;
      idx_q    <= 4'h0;
      narrow_q <= 1'b0;
      cfg_q    <= '{hdr_trl_en: `RCAC_HT_DEF, err_mark_en: `RCAC_MK_DEF,
                    bypass_en: `RCAC_BY_DEF, hit_limit: `RCAC_HL_DEF,
                    err_mask: `RCAC_EM_DEF, buf_size: `RCAC_BS_DEF,
                    coarse_ofs: 11'h000, fine_ofs: 5'h00};
      en_q     <= {128{1'b1}};
      for (int i = 0; i < 128; i++) adj_q[i] <= 8'h00;
    end else if (ce) begin
      st_q     <= st_d;
      op_q     <= op_d;
      left_q   <= left_d;
      idx_q    <= idx_d;
      narrow_q <= narrow_d;
      cfg_q    <= cfg_d;
      en_q     <= en_d;
      adj_q    <= adj_d;
    end
  end

  // Channel offset lookup for the chips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) adj_val_q <= 8'h00;
    else if (ce) adj_val_q <= adj_q[adj_sel];
  end

  assign cfg     = cfg_q;
  assign chan_en = en_q;
  assign adj_val = adj_val_q;

  // ----------------------------------------
  // Event size limit
  // ----------------------------------------
  logic [8:0] hits_q, hits_d, hits_now;
  logic       over;
  logic       errv_q, errv_d, trl_q, trl_d, pend_q, pend_d;

  // Hits so far including this cycle, saturating
  assign hits_now = (ev_hit && hits_q != 9'h1ff) ? hits_q + 9'h001 : hits_q;
  assign over     = (cfg_q.hit_limit <= `RCAC_HL_MAXC)
                  && (hits_now > hl_value(cfg_q.hit_limit));

  // Error word first, trailer slot after it
  always_comb begin
    hits_d = ev_end ? 9'h000 : hits_now;
    errv_d = 1'b0;
    trl_d  = pend_q;
    pend_d = 1'b0;
    if (ev_end) begin
      if (over) begin
        errv_d = 1'b1;
        pend_d = cfg_q.hdr_trl_en;
      end else begin
        trl_d  = cfg_q.hdr_trl_en;
      end
    end
  end

  // Event registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hits_q <= 9'h000;
      errv_q <= 1'b0;
      trl_q  <= 1'b0;
      pend_q <= 1'b0;
    end else if (ce) begin
      hits_q <= hits_d;
      errv_q <= errv_d;
      trl_q  <= trl_d;
      pend_q <= pend_d;
    end
  end

  assign err_valid = errv_q;
  assign err_word  = errv_q ? `RCAC_SIZE_ERR : 16'h0000;
  assign trl_go    = trl_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ht_enable: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && st_q == ST_IDLE && pwdata[15:8] == `RCAC_OP_HT_ON |=> cfg.hdr_trl_en)
    else $error("header enable opcode had no effect");
  a_ht_read: assert property (@(posedge pclk) disable iff (!presetn)
    rd_cmd && st_q == ST_RD && hi_b == `RCAC_OP_HT_RD |-> prdata[0] == cfg.hdr_trl_en)
    else $error("header status word wrong");
  a_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
    st_q != ST_IDLE && !(psel && penable) |=> $stable(st_q) && $stable(left_q))
    else $error("interpreter left wait without transfer");
  a_limit_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && st_q == ST_WR && hi_b == `RCAC_OP_HL_WR
    |=> cfg.hit_limit == $past(pwdata[3:0]) && st_q == ST_IDLE)
    else $error("hit limit not stored");
  a_err_word: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ev_end && over |=> err_valid && err_word == 16'h1000 && !trl_go)
    else $error("size error word missing");
  a_trl_after: assert property (@(posedge pclk) disable iff (!presetn)
    ce && err_valid && cfg.hdr_trl_en && !ev_end ##1 ce |-> trl_go)
    else $error("trailer did not follow error word");
  a_chan_one: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && st_q == ST_IDLE && pwdata[15:8] == `RCAC_OP_CH_ON && pwdata[7:0] < 8'h40
    |=> chan_en[$past(pwdata[5:0])])
    else $error("single channel not enabled");
  a_all_off: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && st_q == ST_IDLE && pwdata[15:8] == `RCAC_OP_ALL_OFF |=> chan_en == '0)
    else $error("channels not all disabled");
  a_unused_op: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && st_q == ST_IDLE && pwdata[15:8] == `RCAC_OP_RC_WR
    |=> $stable(cfg) && $stable(chan_en) && st_q == ST_IDLE)
    else $error("unused opcode changed state");
  a_rd_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == `RCAC_ADDR_CMD && st_q != ST_RD |-> pslverr)
    else $error("command read outside read phase not refused");
  a_pat_word: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && st_q == ST_WR && hi_b == `RCAC_OP_PAT_WR
    |=> chan_en[$past(pat_base) +: 16] == $past(pwdata[15:0]))
    else $error("pattern word not stored");
  a_buf_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && st_q == ST_WR && hi_b == `RCAC_OP_BS_WR
    |=> cfg.buf_size == $past(pwdata[2:0]) && st_q == ST_IDLE)
    else $error("buffer size code not stored");

  // Main scenarios
  c_pattern_done: cover property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_WR && hi_b == `RCAC_OP_PAT_WR ##1 st_q == ST_IDLE);
  c_offset_read: cover property (@(posedge pclk) disable iff (!presetn)
    rd_cmd && hi_b == `RCAC_OP_GO_RD && idx_q == 4'h1);
  c_size_error: cover property (@(posedge pclk) disable iff (!presetn)
    err_valid ##1 trl_go);
  c_narrow_pattern: cover property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && narrow_q && hi_b == `RCAC_OP_PAT_WR && left_q == 4'h1);
endmodule // rcac_core

// [core/rcac_defs.svh]
// Constants of the readout/channel/adjust command interpreter.
// Assumes inclusion by bare name from the package and the core.
`ifndef RCAC_DEFS_SVH
`define RCAC_DEFS_SVH

// ----------------------------------------
// APB register byte addresses
// ----------------------------------------
`define RCAC_ADDR_CMD   12'h000
`define RCAC_ADDR_STAT  12'h004
`define RCAC_ADDR_CFG   12'h008

// ----------------------------------------
// Opcode high bytes
// ----------------------------------------
`define RCAC_OP_HT_ON   8'h30
`define RCAC_OP_HT_OFF  8'h31
`define RCAC_OP_HT_RD   8'h32
`define RCAC_OP_HL_WR   8'h33
`define RCAC_OP_HL_RD   8'h34
`define RCAC_OP_MK_ON   8'h35
`define RCAC_OP_MK_OFF  8'h36
`define RCAC_OP_BY_ON   8'h37
`define RCAC_OP_BY_OFF  8'h38
`define RCAC_OP_EM_WR   8'h39
`define RCAC_OP_EM_RD   8'h3a
`define RCAC_OP_BS_WR   8'h3b
`define RCAC_OP_BS_RD   8'h3c
`define RCAC_OP_CH_ON   8'h40
`define RCAC_OP_CH_OFF  8'h41
`define RCAC_OP_ALL_ON  8'h42
`define RCAC_OP_ALL_OFF 8'h43
`define RCAC_OP_PAT_WR  8'h44
`define RCAC_OP_PAT_RD  8'h45
`define RCAC_OP_CP_WR   8'h46
`define RCAC_OP_CP_RD   8'h47
`define RCAC_OP_GO_WR   8'h50
`define RCAC_OP_GO_RD   8'h51
`define RCAC_OP_ADJ_WR  8'h52
`define RCAC_OP_ADJ_RD  8'h53
`define RCAC_OP_RC_WR   8'h54
`define RCAC_OP_RC_RD   8'h55

// ----------------------------------------
// Reset values, limits and codes
// ----------------------------------------
`define RCAC_HT_DEF     1'b0
`define RCAC_MK_DEF     1'b1
`define RCAC_BY_DEF     1'b0
`define RCAC_HL_DEF     4'h9
`define RCAC_HL_MAXC    4'h8
`define RCAC_EM_DEF     11'h7ff
`define RCAC_BS_DEF     3'h7
`define RCAC_NCH_WIDE   8'h80
`define RCAC_NCH_NARROW 8'h40
`define RCAC_NCP_WIDE   8'h04
`define RCAC_NCP_NARROW 8'h02
`define RCAC_PW_WIDE    4'h8
`define RCAC_PW_NARROW  4'h4
`define RCAC_SIZE_ERR   16'h1000

`endif

// [core/rcac_pkg.sv]
// Types of the readout/channel/adjust command interpreter.
// Assumes rcac_defs.svh is on the include path.
package rcac_pkg;
  `include "rcac_defs.svh"

  // Interpreter phases
  typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD} rcac_state_type;

  // Readout and offset settings driven to the digitizer chips
  typedef struct packed {
    logic        hdr_trl_en;
    logic        err_mark_en;
    logic        bypass_en;
    logic [3:0]  hit_limit;
    logic [10:0] err_mask;
    logic [2:0]  buf_size;
    logic [10:0] coarse_ofs;
    logic [4:0]  fine_ofs;
  } rcac_cfg_type;
endpackage

// [verification/rcac_chip_src.sv]
// Event source standing in for the digitizer chips.
// Assumes pclk from the bench; strobes change just after rising edges.
module rcac_chip_src (
  // Clock
  input  wire logic        pclk,
  // Strobes into the interpreter
  output logic             ev_hit,
  output logic             ev_end,
  // Composition results
  input  wire logic        err_valid,
  input  wire logic [15:0] err_word,
  input  wire logic        trl_go
);
  timeunit 1ns;
  timeprecision 1ps;
  int          err_at;
  int          trl_at;
  logic [15:0] word_seen;

  // ----------------------------------------
  // Event traffic
  // ----------------------------------------
  initial begin
    ev_hit = 1'b0;
    ev_end = 1'b0;
  end

  // One event of some hits, then note when error and trailer slots come
  task automatic send(input int hits);
    int k;
    for (k = 0; k < hits; k++) begin
      @(posedge pclk);
      ev_hit <= 1'b1;
    end
    @(posedge pclk);
    ev_hit <= 1'b0;
    ev_end <= 1'b1;
    @(posedge pclk);
    ev_end <= 1'b0;
    err_at = 0;
    trl_at = 0;
    word_seen = 16'h0000;
    for (k = 1; k <= 4; k++) begin
      @(posedge pclk);
      if (err_valid === 1'b1 && err_at == 0) begin
        err_at = k;
        word_seen = err_word;
      end
      if (trl_go === 1'b1 && trl_at == 0) begin
        trl_at = k;
      end
    end
  endtask
endmodule // rcac_chip_src

// [verification/tb.sv]
// Bench: APB command sequences into the interpreter, answers checked.
// Assumes rcac_pkg, rcac_core and rcac_chip_src are compiled first.
`include "rcac_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcac_pkg::*;
  logic         pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, sl;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, r;
  rcac_cfg_type cfg;
  logic [127:0] chan_en;
  logic [6:0]   adj_sel;
  logic [7:0]   adj_val;
  logic         ev_hit, ev_end, err_valid, trl_go;
  logic [15:0]  err_word;
  int           n_errors, compares, i;

  // ----------------------------------------
  // Clock, design and chip model
  // ----------------------------------------
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  rcac_core dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cfg, .chan_en, .adj_sel, .adj_val,
    .ev_hit, .ev_end, .err_valid, .err_word, .trl_go);

  rcac_chip_src src_u (.pclk, .ev_hit, .ev_end, .err_valid, .err_word, .trl_go);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  // One APB transfer; data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      summarize();
    end
    r = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the edge's register updates settle before outputs are looked at
    @(negedge pclk);
  endtask

  task automatic wr(input logic [15:0] d);
    apb(1'b1, `RCAC_ADDR_CMD, {16'h0000, d});
  endtask

  task automatic rd(input logic [15:0] m, input logic [15:0] e);
    apb(1'b0, `RCAC_ADDR_CMD, 32'h0000_0000);
    chk({16'h0000, r[15:0] & m}, {16'h0000, e});
  endtask

  // Busy, read phase and words left
  task automatic stat(input logic [7:0] e);
    apb(1'b0, `RCAC_ADDR_STAT, 32'h0000_0000);
    chk({24'h00_0000, r[7:0] & 8'hf3}, {24'h00_0000, e});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    adj_sel = 7'h00;
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Defaults
    chk({29'h0, cfg.hdr_trl_en, cfg.err_mark_en, cfg.bypass_en}, 32'h2);
    wr(16'h3200);
    rd(16'h0001, 16'h0000);
    wr(16'h3400);
    rd(16'h000f, 16'h0009);
    wr(16'h3a00);
    rd(16'h07ff, 16'h07ff);
    wr(16'h3c00);
    rd(16'h0007, 16'h0007);
    wr(16'h30ff);
    wr(16'h3255);
    rd(16'h0001, 16'h0001);
    // Hit limit codes 0 to 9 and every buffer size code
    for (i = 0; i < 10; i++) begin
      wr(16'h3300);
      wr(16'hfff0 | i[15:0]);
      wr(16'h3400);
      rd(16'h000f, i[15:0]);
    end
    for (i = 0; i < 8; i++) begin
      wr(16'h3b00);
      wr(16'hfff8 | i[15:0]);
      wr(16'h3c00);
      rd(16'h0007, i[15:0]);
    end
    wr(16'h3900);
    wr(16'hfaaa);
    chk({21'h0, cfg.err_mask}, 32'h2aa);
    wr(16'h3a00);
    rd(16'h07ff, 16'h02aa);
    wr(16'h3600);
    chk({31'h0, cfg.err_mark_en}, 32'h0);
    wr(16'h3500);
    chk({31'h0, cfg.err_mark_en}, 32'h1);
    wr(16'h3700);
    chk({31'h0, cfg.bypass_en}, 32'h1);
    wr(16'h3800);
    chk({31'h0, cfg.bypass_en}, 32'h0);
    // Enable low holds the bus answer back
    @(posedge pclk);
    ce <= 1'b0;
    @(negedge pclk);
    chk({31'h0, pready}, 32'h0);
    @(posedge pclk);
    ce <= 1'b1;
    // Operand waits and global offset
    wr(16'h5000);
    stat(8'h21);
    wr(16'hffff);
    stat(8'h11);
    wr(16'h00ff);
    stat(8'h00);
    chk({16'h0, cfg.coarse_ofs, cfg.fine_ofs}, 32'hffff);
    wr(16'h5100);
    stat(8'h23);
    rd(16'h07ff, 16'h07ff);
    rd(16'h001f, 16'h001f);
    stat(8'h00);
    apb(1'b1, 12'h0fc, 32'h0000_3100);
    chk({31'h0, sl}, 32'h1);
    apb(1'b0, `RCAC_ADDR_CMD, 32'h0000_0000);
    chk({31'h0, sl}, 32'h1);
    // Channel enables
    wr(16'h4300);
    chk({31'h0, |chan_en}, 32'h0);
    wr(16'h407f);
    chk({31'h0, chan_en[127]}, 32'h1);
    wr(16'h4005);
    chk(chan_en[31:0], 32'h0000_0020);
    wr(16'h4105);
    chk(chan_en[31:0], 32'h0000_0000);
    wr(16'h4200);
    chk({31'h0, &chan_en}, 32'h1);
    wr(16'h4400);
    for (i = 0; i < 8; i++) wr({i[7:0], ~i[7:0]});
    for (i = 0; i < 8; i++) chk({16'h0, chan_en[16*i+:16]}, {16'h0, i[7:0], ~i[7:0]});
    wr(16'h4500);
    for (i = 0; i < 8; i++) rd(16'hffff, {i[7:0], ~i[7:0]});
    wr(16'h4602);
    wr(16'h1234);
    wr(16'h5678);
    chk(chan_en[95:64], 32'h5678_1234);
    chk(chan_en[31:0], 32'h01fe_00ff);
    wr(16'h4702);
    rd(16'hffff, 16'h1234);
    rd(16'hffff, 16'h5678);
    // Narrow variant takes four pattern words
    apb(1'b1, `RCAC_ADDR_CFG, 32'h0000_0001);
    wr(16'h4400);
    for (i = 0; i < 4; i++) wr(16'hffff);
    stat(8'h00);
    wr(16'h4500);
    for (i = 0; i < 4; i++) rd(16'hffff, 16'hffff);
    stat(8'h00);
    apb(1'b1, `RCAC_ADDR_CFG, 32'h0000_0000);
    // Channel offsets and unused opcodes
    wr(16'h5233);
    wr(16'hab5c);
    wr(16'h5333);
    rd(16'h00ff, 16'h005c);
    wr(16'h5334);
    rd(16'h00ff, 16'h0000);
    @(posedge pclk);
    adj_sel <= 7'h33;
    repeat (2) @(posedge pclk);
    chk({24'h0, adj_val}, 32'h5c);
    wr(16'h5401);
    stat(8'h00);
    wr(16'h5501);
    stat(8'h00);
    // Size limit error ahead of trailer
    wr(16'h3000);
    wr(16'h3300);
    wr(16'h0001);
    src_u.send(2);
    chk(src_u.err_at, 32'd1);
    chk({16'h0, src_u.word_seen}, 32'h1000);
    chk(src_u.trl_at, 32'd2);
    src_u.send(1);
    chk(src_u.err_at * 8 + src_u.trl_at, 32'd1);
    wr(16'h3100);
    src_u.send(2);
    chk(src_u.err_at * 8 + src_u.trl_at, 32'd8);
    wr(16'h3300);
    wr(16'h0009);
    src_u.send(3);
    chk(src_u.err_at, 32'd0);
    summarize();
  end
endmodule // tb
